/* rtl/ppl_pin_location.sv */
// Pin location select: four location registers on a Wishbone slave and the
// multiplexers that route the serial clock and three modem inputs to pins.
// Assumes per-pin function-select logic outside reports, per candidate pin,
// whether that pin's function field picks the relocatable signal.
//
// Summary of operation
// R01: The serial clock location field in bits 1:0 picks candidate pin 0, 1 or 2; code 3 is reserved; reset 0.
// R02: A relocatable signal reaches a pin only when the location selects that pin and the pin's own function picks it.
// R03: The set-ready location field in bits 1:0 picks the port-2 pin on 0 or the port-3 pin on 1; reset 0.
// R04: The carrier location field in bits 1:0 takes the input from the port-2 pin on 0 or the port-3 pin on 1, reset 0.
// R05: The ring location field in bits 1:0 takes the input from the port-2 pin on 0 or the port-3 pin on 1, reset 0.
// R06: The modem location registers act only on the later variant; otherwise the inputs stay on their port-2 pins.
// R07: Software must program both the per-pin function fields and the modem location registers to use port-3 pins.
// R08: Bits 31:2 of each location register read zero and ignore writes, and a reserved code connects no pin.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps

module ppl_pin_location #(
    parameter bit LATER_VARIANT = 1'b1,
    parameter bit MODEM_IDLE = 1'b1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire ppl_pkg::ppl_wb_req_t wb_req,
    output ppl_pkg::ppl_wb_rsp_t wb_rsp,
    input wire logic ssp_serial_clock_out,
    input wire logic ssp_serial_clock_oe,
    input wire logic [2:0] sck_pin_in,
    input wire logic [2:0] sck_pin_function_select,
    output ppl_pkg::ppl_sck_pins_t sck_pins,
    output logic ssp_serial_clock_in,
    input wire logic [1:0] set_ready_pin_in,
    input wire logic [1:0] set_ready_pin_function_select,
    input wire logic [1:0] carrier_pin_in,
    input wire logic [1:0] carrier_pin_function_select,
    input wire logic [1:0] ring_pin_in,
    input wire logic [1:0] ring_pin_function_select,
    output logic set_ready_input,
    output logic carrier_detect_input,
    output logic ring_indicator_input
);

    // ************************************************************
    // Routing helpers
    // ************************************************************

    // One-hot pin choice for the serial clock; reserved code gives no pin
    function automatic logic [2:0] sck_pin_pick(input logic [1:0] loc, input logic [2:0] pin_function_select);
        logic [2:0] hot;
        hot = 3'h0;
        case (loc)
            ppl_pkg::SCK_LOC_PIN0: hot = 3'h1; // see R01
            ppl_pkg::SCK_LOC_PIN1: hot = 3'h2; // see R01
            ppl_pkg::SCK_LOC_PIN2: hot = 3'h4; // see R01
            default: hot = 3'h0; // see R08
        endcase
        return hot & pin_function_select; // see R02
    endfunction

    // Modem input from its port-2 or port-3 candidate; idle when unrouted
    function automatic logic modem_route(input logic [1:0] loc, input logic [1:0] pin,
                                         input logic [1:0] pin_function_select);
        logic [1:0] eff;
        logic v;
        eff = LATER_VARIANT ? loc : ppl_pkg::MODEM_LOC_PORT2; // see R06
        v = MODEM_IDLE;
        case (eff)
            ppl_pkg::MODEM_LOC_PORT2: begin
                v = pin_function_select[0] ? pin[0] : MODEM_IDLE; // see R02
            end
            ppl_pkg::MODEM_LOC_PORT3: begin
                v = pin_function_select[1] ? pin[1] : MODEM_IDLE; // see R02
            end
            default: v = MODEM_IDLE; // see R08
        endcase
        return v;
    endfunction

    // Location word as read back; upper bits are always zero
    function automatic logic [31:0] loc_word(input logic [1:0] loc);
        logic [31:0] w;
        w = 32'h0;
        w[ppl_pkg::LOC_LSB +: ppl_pkg::LOC_W] = loc; // see R08
        return w;
    endfunction

    // Register slot of a byte address; slot 4 means no register lives there
    function automatic logic [2:0] reg_slot(input logic [31:0] adr);
        logic [2:0] slot;
        slot = 3'h4;
        case (adr)
            ppl_pkg::SCK_LOC_ADDR: slot = 3'h0;
            ppl_pkg::DSR_LOC_ADDR: slot = 3'h1;
            ppl_pkg::DCD_LOC_ADDR: slot = 3'h2;
            ppl_pkg::RI_LOC_ADDR: slot = 3'h3;
            default: slot = 3'h4;
        endcase
        return slot;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    ppl_pkg::ppl_state_t st_r;
    ppl_pkg::ppl_state_t st_nxt;

    logic req;
    logic wr_lo;
    logic [1:0] wfield;
    logic [2:0] sck_hot;
    logic [2:0] req_slot;

    assign req = wb_req.cyc & wb_req.stb;
    assign req_slot = reg_slot(wb_req.adr);
    // Only byte lane 0 holds a field, so other lanes cannot change anything
    assign wr_lo = req & wb_req.we & wb_req.sel[0] & ~st_r.ack;
    assign wfield = wb_req.dat[ppl_pkg::LOC_LSB +: ppl_pkg::LOC_W];
    assign sck_hot = sck_pin_pick(st_r.serial_clock_location_field, sck_pin_function_select);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;

        // Single-cycle answer; ack drops the cycle after it was given
        st_nxt.ack = req & ~st_r.ack;
        st_nxt.rdat = 32'h0;
        if (req & ~wb_req.we & ~st_r.ack) begin
            case (req_slot)
                3'h0: st_nxt.rdat = loc_word(st_r.serial_clock_location_field);
                3'h1: st_nxt.rdat = loc_word(st_r.set_ready_location_field);
                3'h2: st_nxt.rdat = loc_word(st_r.carrier_location_field);
                3'h3: st_nxt.rdat = loc_word(st_r.ring_location_field);
                default: st_nxt.rdat = 32'h0;
            endcase
        end

        if (wr_lo) begin
            case (req_slot)
                3'h0: begin
                    st_nxt.serial_clock_location_field = wfield; // see R01
                end
                3'h1: begin
                    st_nxt.set_ready_location_field = wfield; // see R03
                end
                3'h2: begin
                    st_nxt.carrier_location_field = wfield; // see R04
                end
                3'h3: begin
                    st_nxt.ring_location_field = wfield; // see R05
                end
                default: begin
                    // Unmapped writes are acknowledged and dropped
                    st_nxt.ring_location_field = st_r.ring_location_field;
                end
            endcase
        end

        // Serial clock drive: only the selected, function-matched pin drives
        st_nxt.sck_pins.out = sck_hot & {3{ssp_serial_clock_out}}; // see R01, R02
        st_nxt.sck_pins.oe = sck_hot & {3{ssp_serial_clock_oe}}; // see R02
        // Clock back to the port from the routed pin, low when none is routed
        st_nxt.sck_to_ssp = |(sck_hot & sck_pin_in); // see R01, R02

        st_nxt.set_ready = modem_route(st_r.set_ready_location_field, set_ready_pin_in,
                                       set_ready_pin_function_select); // see R03
        st_nxt.carrier_detect = modem_route(st_r.carrier_location_field, carrier_pin_in,
                                            carrier_pin_function_select); // see R04
        st_nxt.ring_indicator = modem_route(st_r.ring_location_field, ring_pin_in,
                                            ring_pin_function_select); // see R05
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r.ack <= 1'b0;
            st_r.rdat <= 32'h0;
            st_r.serial_clock_location_field <= ppl_pkg::LOC_RESET; // see R01
            st_r.set_ready_location_field <= ppl_pkg::LOC_RESET; // see R03
            st_r.carrier_location_field <= ppl_pkg::LOC_RESET; // see R04
            st_r.ring_location_field <= ppl_pkg::LOC_RESET; // see R05
            st_r.sck_pins <= '0;
            st_r.sck_to_ssp <= 1'b0;
            st_r.set_ready <= MODEM_IDLE;
            st_r.carrier_detect <= MODEM_IDLE;
            st_r.ring_indicator <= MODEM_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Routed signals are registered, so a pin change shows one cycle late
    assign wb_rsp.ack = st_r.ack;
    assign wb_rsp.dat = st_r.rdat;
    assign sck_pins = st_r.sck_pins;
    assign ssp_serial_clock_in = st_r.sck_to_ssp;
    assign set_ready_input = st_r.set_ready;
    assign carrier_detect_input = st_r.carrier_detect;
    assign ring_indicator_input = st_r.ring_indicator;

endmodule

/* rtl/ppl_pkg.sv */
// Package of the pin location select block: register map, field layout,
// location codes and the bus and state carriers.
// Assumes a classic Wishbone slave port with 32-bit data and byte addresses.
package ppl_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [31:0] SCK_LOC_ADDR = 32'h400440B0;
    localparam logic [31:0] DSR_LOC_ADDR = 32'h400440B4;
    localparam logic [31:0] DCD_LOC_ADDR = 32'h400440B8;
    localparam logic [31:0] RI_LOC_ADDR = 32'h400440BC;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int LOC_LSB = 0;
    localparam int LOC_W = 2;
    localparam logic [1:0] LOC_RESET = 2'h0;

    // ************************************************************
    // Location codes
    // ************************************************************
    localparam logic [1:0] SCK_LOC_PIN0 = 2'h0;
    localparam logic [1:0] SCK_LOC_PIN1 = 2'h1;
    localparam logic [1:0] SCK_LOC_PIN2 = 2'h2;
    localparam logic [1:0] MODEM_LOC_PORT2 = 2'h0;
    localparam logic [1:0] MODEM_LOC_PORT3 = 2'h1;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
    } ppl_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ppl_wb_rsp_t;

    // Serial clock candidate pins, one bit per pin
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } ppl_sck_pins_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [1:0] serial_clock_location_field;
        logic [1:0] set_ready_location_field;
        logic [1:0] carrier_location_field;
        logic [1:0] ring_location_field;
        ppl_sck_pins_t sck_pins;
        logic sck_to_ssp;
        logic set_ready;
        logic carrier_detect;
        logic ring_indicator;
    } ppl_state_t;

endpackage

/* test/ppl_pin_location_checker.sv */
// Checker of the pin location select block: bus handshake and routing relations.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps

module ppl_pin_location_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire ppl_pkg::ppl_wb_req_t wb_req,
    input wire ppl_pkg::ppl_wb_rsp_t wb_rsp,
    input wire logic [2:0] sck_pin_in,
    input wire logic [2:0] sck_pin_function_select,
    input wire ppl_pkg::ppl_sck_pins_t sck_pins,
    input wire logic ssp_serial_clock_in,
    input wire logic [1:0] set_ready_pin_in,
    input wire logic [1:0] set_ready_pin_function_select,
    input wire logic [1:0] carrier_pin_in,
    input wire logic [1:0] carrier_pin_function_select,
    input wire logic [1:0] ring_pin_in,
    input wire logic [1:0] ring_pin_function_select,
    input wire logic set_ready_input,
    input wire logic carrier_detect_input,
    input wire logic ring_indicator_input
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ************
    // Assertions
    // ************
    property p_ack; wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_ack_once; wb_rsp.ack |=> !wb_rsp.ack; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_dat_idle; !wb_rsp.ack |-> wb_rsp.dat == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_oe_one; $onehot0(sck_pins.oe); endproperty
    a_oe_one: assert property (p_oe_one) else $error("serial clock on two pins");
    property p_oe_sel; 1'b1 |=> (sck_pins.oe & ~$past(sck_pin_function_select)) == 3'h0; endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("clock driven on unselected pin");
    property p_clk_in;
        ssp_serial_clock_in |-> ($past(sck_pin_in) & $past(sck_pin_function_select)) != 3'h0;
    endproperty
    a_clk_in: assert property (p_clk_in) else $error("clock input from unselected pin");
    property p_sr;
        !set_ready_input |-> (~$past(set_ready_pin_in) & $past(set_ready_pin_function_select)) != 2'h0;
    endproperty
    a_sr: assert property (p_sr) else $error("set ready low without selected pin");
    property p_cd;
        !carrier_detect_input |-> (~$past(carrier_pin_in) & $past(carrier_pin_function_select)) != 2'h0;
    endproperty
    a_cd: assert property (p_cd) else $error("carrier low without selected pin");
    property p_ri;
        !ring_indicator_input |-> (~$past(ring_pin_in) & $past(ring_pin_function_select)) != 2'h0;
    endproperty
    a_ri: assert property (p_ri) else $error("ring low without selected pin");
endmodule

/* test/ppl_pin_location_bench.sv */
// Bench of the pin location select block: register access and pin routing against a model.
// Assumes the package and the checker are compiled before this file.
`timescale 1ns/1ps

module ppl_pin_location_bench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    ppl_pkg::ppl_wb_req_t wb_req = '0;
    ppl_pkg::ppl_wb_rsp_t wb_rsp;
    ppl_pkg::ppl_sck_pins_t sck_pins;
    logic [19:0] pin_v = '0;
    logic clk_in, sr_o, cd_o, ri_o;
    logic sr_f, cd_f, ri_f;
    logic [1:0] fld [4];
    logic [31:0] q, d, a;
    logic [2:0] hot;
    int err_count = 0, num_checks = 0, seed = 61467, cyc_n = 0;
    always #2 mclk = ~mclk;
    ppl_pin_location i_ppl_pin_location (.mclk(mclk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .ssp_serial_clock_out(pin_v[19]), .ssp_serial_clock_oe(pin_v[18]), .sck_pin_in(pin_v[17:15]),
        .sck_pin_function_select(pin_v[14:12]), .sck_pins(sck_pins), .ssp_serial_clock_in(clk_in),
        .set_ready_pin_in(pin_v[11:10]), .set_ready_pin_function_select(pin_v[9:8]),
        .carrier_pin_in(pin_v[7:6]), .carrier_pin_function_select(pin_v[5:4]), .ring_pin_in(pin_v[3:2]),
        .ring_pin_function_select(pin_v[1:0]), .set_ready_input(sr_o), .carrier_detect_input(cd_o),
        .ring_indicator_input(ri_o));
    // Earlier variant: modem locations are stored but routing keeps the fixed pins
    ppl_pin_location #(.LATER_VARIANT(1'b0), .MODEM_IDLE(1'b1)) i_ppl_pin_location_fixed (.mclk(mclk),
        .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(), .ssp_serial_clock_out(pin_v[19]),
        .ssp_serial_clock_oe(pin_v[18]), .sck_pin_in(pin_v[17:15]), .sck_pin_function_select(pin_v[14:12]),
        .sck_pins(), .ssp_serial_clock_in(), .set_ready_pin_in(pin_v[11:10]), .set_ready_pin_function_select(pin_v[9:8]),
        .carrier_pin_in(pin_v[7:6]), .carrier_pin_function_select(pin_v[5:4]), .ring_pin_in(pin_v[3:2]),
        .ring_pin_function_select(pin_v[1:0]), .set_ready_input(sr_f), .carrier_detect_input(cd_f),
        .ring_indicator_input(ri_f));
    // ************
    // Tasks
    // ************
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waits for ack with no assumed latency; the model updates at the ack edge
    task wb(input logic w, input logic [31:0] ad, input logic [31:0] dw, input logic [3:0] s);
        @(posedge mclk);
        wb_req <= {2'b11, w, ad, dw, s};
        do @(posedge mclk); while (wb_rsp.ack !== 1'b1);
        q = wb_rsp.dat;
        wb_req <= '0;
        if (w && s[0] && ad[31:4] == ppl_pkg::SCK_LOC_ADDR[31:4] && ad[1:0] == 2'h0) fld[ad[3:2]] = dw[1:0];
    endtask
    function automatic logic [31:0] mdm(input logic [1:0] c, input logic [1:0] i, input logic [1:0] f);
        return (c < 2'h2 && f[c[0]]) ? {31'h0, i[c[0]]} : 32'h1;
    endfunction
    task chk_routes;
        hot = (fld[0] < 2'h3) ? 3'(3'h1 << fld[0]) & pin_v[14:12] : 3'h0;
        chk("sck oe", {29'h0, hot & {3{pin_v[18]}}}, {29'h0, sck_pins.oe});
        chk("sck out", {29'h0, hot & {3{pin_v[19]}}}, {29'h0, sck_pins.out});
        chk("sck in", {31'h0, |(hot & pin_v[17:15])}, {31'h0, clk_in});
        chk("set ready", mdm(fld[1], pin_v[11:10], pin_v[9:8]), {31'h0, sr_o});
        chk("carrier", mdm(fld[2], pin_v[7:6], pin_v[5:4]), {31'h0, cd_o});
        chk("ring", mdm(fld[3], pin_v[3:2], pin_v[1:0]), {31'h0, ri_o});
        chk("fixed set ready", mdm(2'h0, pin_v[11:10], pin_v[9:8]), {31'h0, sr_f});
        chk("fixed carrier", mdm(2'h0, pin_v[7:6], pin_v[5:4]), {31'h0, cd_f});
        chk("fixed ring", mdm(2'h0, pin_v[3:2], pin_v[1:0]), {31'h0, ri_f});
    endtask
    // ************
    // Main sequence
    // ************
    initial begin
        // Second pass starts with a reset in mid-run, fields left at code 3 except the carrier field at code 2
        for (int p = 0; p < 2; p++) begin
            repeat (11) @(posedge mclk);
            #1;
            chk("reset outputs", 32'h7, {22'h0, sck_pins, clk_in, sr_o, cd_o, ri_o});
            @(posedge mclk);
            sys_rst <= 1'b0;
            foreach (fld[i]) fld[i] = 2'h0;
            for (int r = 0; r < 5; r++) begin
                wb(1'b0, ppl_pkg::SCK_LOC_ADDR + 32'(4 * r), 32'h0, 4'hF);
                chk("reset read", 32'h0, q);
            end
            // Fifth slot is unmapped; sel lane 0 is dropped now and then
            for (int k = 0; k < 80; k++) begin
                d = $random(seed);
                a = ppl_pkg::SCK_LOC_ADDR + 32'(4 * (k % 5));
                wb(1'b1, a, {d[31:2], 2'((k / 5) % 4)}, {d[7:5], k % 7 != 0});
                wb(1'b0, a, d, 4'hF);
                chk("register read", (k % 5 < 4) ? {30'h0, fld[k % 5]} : 32'h0, q);
                repeat (3) begin
                    @(posedge mclk);
                    pin_v <= 20'($random(seed));
                    repeat (2) @(posedge mclk);
                    #1;
                    chk_routes;
                end
            end
            @(posedge mclk);
            sys_rst <= 1'b1;
        end
        end_sim;
    end
    always @(posedge mclk) begin
        cyc_n++;
        if (cyc_n == 8000) begin
            err_count++;
            end_sim;
        end
    end
endmodule

bind ppl_pin_location ppl_pin_location_checker i_ppl_pin_location_checker (.mclk(mclk), .sys_rst(sys_rst),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .sck_pin_in(sck_pin_in), .sck_pin_function_select(sck_pin_function_select),
    .sck_pins(sck_pins), .ssp_serial_clock_in(ssp_serial_clock_in), .set_ready_pin_in(set_ready_pin_in),
    .set_ready_pin_function_select(set_ready_pin_function_select), .carrier_pin_in(carrier_pin_in),
    .carrier_pin_function_select(carrier_pin_function_select), .ring_pin_in(ring_pin_in),
    .ring_pin_function_select(ring_pin_function_select), .set_ready_input(set_ready_input),
    .carrier_detect_input(carrier_detect_input), .ring_indicator_input(ring_indicator_input));
